/* hdl/line_polarity_collision_aui_status.sv */
// Line polarity, collision, port select and AUI carrier supervision
// Operation
// - Polarity status bit is high when normal, low once reversal is found.
// - Disable bit clear inverts received data on reversal; set applies none.
// - Polarity status bit follows the line regardless of the disable bit.
// - Reversed after an inverted link pulse and four negative EOFs in a row.
// - Receive data arriving while a reversal is suspected but not declared is discarded.
// - Half duplex: twisted-pair transmit with receive raises MAC collision.
// - AUI carrier absent or lost during transmit sets the carrier-lost bit.
// - Activity on the AUI collision pair raises the MAC collision signal.
// - AUI-only picks AUI, auto bit picks automatic, else twisted pair only.
// - Automatic mode uses twisted pair while it shows activity, else AUI.
`timescale 1ns/1ps
`include "line_status_map.svh"

module line_polarity_collision_aui_status #(
  parameter int unsigned LINK_LOSS_CYC = `LINK_LOSS_CYC
) (
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          resetn,
  input  wire logic                          clk_en,
  // Register port
  input  wire logic [`ADDR_W-1:0]            reg_addr,
  input  wire logic [`DATA_W-1:0]            reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [`DATA_W-1:0]            reg_rdata,
  // Line side
  input  line_status_pkg::line_in_t          line_in,
  // MAC side
  input  wire logic                          mac_tx_active,
  output line_status_pkg::mac_out_t          mac_out,
  output line_status_pkg::port_sel_t         port_sel
);
  import line_status_pkg::*;

  line_in_t                 sync1_r;
  line_in_t                 sync2_r;
  line_in_t                 prev_r;
  logic [`DATA_W-1:0]       line_ctl_r;
  logic [`DATA_W-1:0]       test_ctl_r;
  logic                     lost_crs_r;
  logic [2:0]               neg_cnt_r;
  logic [2:0]               pos_cnt_r;
  logic                     inv_seen_r;
  logic                     reversed_r;
  logic                     drop_frame_r;
  logic [`COL_CNT_W-1:0]    col_cnt_r;
  logic [`LINK_CNT_W-1:0]   link_cnt_r;
  logic                     tx_prev_r;
  logic                     crs_seen_r;
  logic                     pol_dis;
  logic                     aui_only;
  logic                     auto_sel;
  logic                     full_duplex_select;
  logic                     link_pulse_ev;
  logic                     link_inv_ev;
  logic                     eof_pos_ev;
  logic                     eof_neg_ev;
  logic                     rx_start_ev;
  logic                     ci_edge;
  logic                     tp_alive;
  logic                     lost_set;
  logic                     lost_clr;
  logic                     suspect;
  port_sel_t                port_nxt;
  logic                     recover;
  logic                     lost_drop;
  logic                     lost_never;
  logic [`DATA_W-1:0]       status_word;
  logic [`DATA_W-1:0]       txev_word;

  assign pol_dis  = line_ctl_r[`CTL_POL_DIS_BIT];
  assign aui_only = line_ctl_r[`CTL_AUI_ONLY_BIT];
  assign auto_sel = line_ctl_r[`CTL_AUTO_SEL_BIT];
  assign full_duplex_select      = test_ctl_r[`TEST_FDX_BIT];

  // Two-stage synchroniser, third stage only for edge detection
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r  <= '0;
    end else if (clk_en) begin
      sync1_r <= line_in;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // Edges only after the second stage
  assign link_pulse_ev = sync2_r.tp_link_pulse & ~prev_r.tp_link_pulse;
  assign link_inv_ev   = sync2_r.tp_link_inv & ~prev_r.tp_link_inv;
  assign eof_pos_ev    = sync2_r.tp_eof_pos & ~prev_r.tp_eof_pos;
  assign eof_neg_ev    = sync2_r.tp_eof_neg & ~prev_r.tp_eof_neg;
  assign rx_start_ev   = sync2_r.tp_rx_active & ~prev_r.tp_rx_active;
  assign ci_edge       = sync2_r.aui_collision ^ prev_r.aui_collision;

  // Control registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      line_ctl_r <= `LINE_CTL_RST;
      test_ctl_r <= `TEST_CTL_RST;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == `LINE_CTL_IDX)
        line_ctl_r <= reg_wdata;
      if (reg_addr == `TEST_CTL_IDX)
        test_ctl_r <= reg_wdata;
    end
  end

  // Status and event words; polarity bit ignores the disable bit
  always_comb begin
    status_word                     = `DATA_ZERO;
    status_word[`ST_POL_OK_BIT]     = ~reversed_r;
    status_word[`ST_CRS_BIT]        = mac_out.carrier;
    status_word[`ST_LINK_ALIVE_BIT] = tp_alive;
    status_word[`ST_AUI_SEL_BIT]    = (port_sel == PORT_AUI);
  end

  always_comb begin
    txev_word                     = `DATA_ZERO;
    txev_word[`TXEV_LOST_CRS_BIT] = lost_crs_r;
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= `DATA_ZERO;
    end else if (clk_en) begin
      reg_rdata <= `DATA_ZERO;
      if (reg_rd) begin
        unique case (reg_addr)
          `LINE_CTL_IDX: reg_rdata <= line_ctl_r;
          `TEST_CTL_IDX: reg_rdata <= test_ctl_r;
          `TX_EVENT_IDX: reg_rdata <= txev_word;
          `LINE_ST_IDX:  reg_rdata <= status_word;
          default: reg_rdata <= `DATA_ZERO;
        endcase
      end
    end
  end

  // Polarity detection; ignores the disable bit on purpose
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      neg_cnt_r  <= `CNT3_ZERO;
      inv_seen_r <= 1'b0;
    end else if (clk_en) begin
      if (link_inv_ev)
        inv_seen_r <= 1'b1;
      else if (recover)
        inv_seen_r <= 1'b0;
      // Old negative frames must not count towards a new reversal
      if (eof_pos_ev || recover)
        neg_cnt_r <= `CNT3_ZERO;
      else if (eof_neg_ev && neg_cnt_r != `NEG_FRAMES_MIN)
        neg_cnt_r <= neg_cnt_r + `CNT3_ONE;
    end
  end

  // Consecutive normal link pulses, broken by any inverted one
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pos_cnt_r <= `CNT3_ZERO;
    end else if (clk_en) begin
      if (link_inv_ev || !reversed_r)
        pos_cnt_r <= `CNT3_ZERO;
      else if (link_pulse_ev && pos_cnt_r != `POS_PULSES_MIN)
        pos_cnt_r <= pos_cnt_r + `CNT3_ONE;
    end
  end

  // Reversal is sticky so a single clean pulse cannot flip it back
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reversed_r <= 1'b0;
    end else if (clk_en) begin
      if (inv_seen_r && neg_cnt_r == `NEG_FRAMES_MIN)
        reversed_r <= 1'b1;
      else if (recover)
        reversed_r <= 1'b0;
    end
  end

  // Enough clean link pulses while reversed
  assign recover = reversed_r & (pos_cnt_r == `POS_PULSES_MIN);

  // Reversal suspected but not yet declared
  assign suspect = ~reversed_r & (inv_seen_r | (neg_cnt_r != `CNT3_ZERO));

  // Whole frame dropped if it began while polarity was unresolved
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      drop_frame_r <= 1'b0;
    end else if (clk_en) begin
      if (rx_start_ev)
        drop_frame_r <= suspect;
    end
  end

  // Twisted-pair activity timer for automatic selection
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      link_cnt_r <= '0;
    end else if (clk_en) begin
      if (link_pulse_ev || link_inv_ev || sync2_r.tp_rx_active)
        link_cnt_r <= LINK_LOSS_CYC[`LINK_CNT_W-1:0];
      else if (link_cnt_r != '0)
        link_cnt_r <= link_cnt_r - 1'b1;
    end
  end

  assign tp_alive = (link_cnt_r != '0);

  // AUI-only outranks auto-select
  always_comb begin
    if (aui_only)
      port_nxt = PORT_AUI;
    else if (auto_sel)
      port_nxt = tp_alive ? PORT_TP : PORT_AUI;
    else
      port_nxt = PORT_TP;
  end

  // Registered so the port output comes from a flop
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      port_sel <= PORT_TP;
    else if (clk_en)
      port_sel <= port_nxt;
  end

  // Stretch each collision-pair edge so a 10 MHz signal reads steady
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      col_cnt_r <= '0;
    end else if (clk_en) begin
      if (ci_edge)
        col_cnt_r <= `COL_CNT_W'(`COL_HOLD_CYC);
      else if (col_cnt_r != '0)
        col_cnt_r <= col_cnt_r - 1'b1;
    end
  end

  // MAC indications
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mac_out <= '0;
    end else if (clk_en) begin
      if (port_sel == PORT_TP) begin
        mac_out.collision <= ~full_duplex_select & mac_tx_active
                             & sync2_r.tp_rx_active;
        mac_out.carrier   <= sync2_r.tp_rx_active;
        mac_out.rx_valid  <= sync2_r.tp_rx_active
                             & ~drop_frame_r & ~suspect;
        mac_out.rx_data   <= sync2_r.tp_rx_data
                             ^ (reversed_r & ~pol_dis);
      end else begin
        mac_out.collision <= (col_cnt_r != '0);
        mac_out.carrier   <= sync2_r.aui_carrier;
        mac_out.rx_valid  <= sync2_r.aui_carrier;
        mac_out.rx_data   <= sync2_r.tp_rx_data;
      end
    end
  end

  // AUI loopback carrier supervision during transmit
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_prev_r  <= 1'b0;
      crs_seen_r <= 1'b0;
    end else if (clk_en) begin
      tx_prev_r <= mac_tx_active;
      if (mac_tx_active && !tx_prev_r)
        crs_seen_r <= 1'b0;
      else if (mac_tx_active && sync2_r.aui_carrier)
        crs_seen_r <= 1'b1;
    end
  end

  // Carrier seen then lost mid-frame, or never seen at all
  assign lost_drop  = crs_seen_r & ~sync2_r.aui_carrier & mac_tx_active;
  assign lost_never = ~mac_tx_active & ~crs_seen_r;
  assign lost_set   = (port_sel == PORT_AUI) & tx_prev_r
                      & (lost_drop | lost_never);
  assign lost_clr = reg_rd & (reg_addr == `TX_EVENT_IDX);

  // Clear on read; a new event in the same cycle wins
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      lost_crs_r <= 1'b0;
    else if (clk_en) begin
      if (lost_set)
        lost_crs_r <= 1'b1;
      else if (lost_clr)
        lost_crs_r <= 1'b0;
    end
  end

endmodule // line_polarity_collision_aui_status

/* hdl/line_status_map.svh */
// Register offsets, bit positions and timing figures of the line block
`ifndef LINE_STATUS_MAP_SVH
`define LINE_STATUS_MAP_SVH

`define ADDR_W             5
`define DATA_W             16
`define TX_EVENT_IDX       5'h08
`define LINE_CTL_IDX       5'h0D
`define LINE_ST_IDX        5'h0E
`define TEST_CTL_IDX       5'h13

`define CTL_AUI_ONLY_BIT   8
`define CTL_AUTO_SEL_BIT   9
`define CTL_POL_DIS_BIT    12
`define ST_AUI_SEL_BIT     3
`define ST_LINK_ALIVE_BIT  7
`define ST_POL_OK_BIT      12
`define ST_CRS_BIT         14
`define TXEV_LOST_CRS_BIT  6
`define TEST_FDX_BIT       14

`define LINE_CTL_RST       16'h0000
`define TEST_CTL_RST       16'h0000
`define DATA_ZERO          16'h0000

`define NEG_FRAMES_MIN     3'h4
`define POS_PULSES_MIN     3'h4
`define CNT3_ZERO          3'h0
`define CNT3_ONE           3'h1

`define CLK_PERIOD_NS      20
`define COL_HOLD_NS        250
`define COL_HOLD_CYC       (`COL_HOLD_NS / `CLK_PERIOD_NS)
`define COL_CNT_W          4
`define LINK_LOSS_MS       50
`define LINK_LOSS_CYC      (`LINK_LOSS_MS * 1000000 / `CLK_PERIOD_NS)
`define LINK_CNT_W         22

`endif

/* hdl/line_status_pkg.sv */
// Types shared by the line status and supervision block
package line_status_pkg;

  // Line-side indications; link pulses, EOFs and collision pair are taken by edge, the rest as levels
  typedef struct packed {
    logic tp_rx_active;
    logic tp_rx_data;
    logic tp_link_pulse;
    logic tp_link_inv;
    logic tp_eof_pos;
    logic tp_eof_neg;
    logic aui_carrier;
    logic aui_collision;
  } line_in_t;

  // Indications towards the MAC
  typedef struct packed {
    logic collision;
    logic carrier;
    logic rx_valid;
    logic rx_data;
  } mac_out_t;

  typedef enum logic {PORT_TP, PORT_AUI} port_sel_t;

endpackage

/* sim/line_far_end.sv */
// Far-end transceiver model: carrier echo and collision tone
`timescale 1ns/1ps
module line_far_end (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // Bench controls
  input  wire logic mac_tx_active,
  input  wire logic loop_en,
  input  wire logic col_en,
  // Line outputs
  output logic      aui_carrier,
  output logic      aui_collision
);
  logic [1:0] echo_r;
  logic [1:0] ph_r;
  // Cable delay of two cycles on the echo
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) echo_r <= 2'h0;
    else echo_r <= {echo_r[0], mac_tx_active & loop_en};
  end
  assign aui_carrier = echo_r[1];
  // Nearest to the collision tone this clock allows
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ph_r          <= 2'h0;
      aui_collision <= 1'b0;
    end else if (!col_en) begin
      ph_r          <= 2'h0;
      aui_collision <= 1'b0;
    end else if (ph_r == 2'h2) begin
      ph_r          <= 2'h0;
      aui_collision <= ~aui_collision;
    end else ph_r <= ph_r + 2'h1;
  end
endmodule // line_far_end

/* sim/line_status_monitor.sv */
// Assertion checker for the line status block
`timescale 1ns/1ps
`include "line_status_map.svh"
module line_status_monitor (
  // Clock and reset
  input wire logic                 core_clk,
  input wire logic                 resetn,
  input wire logic                 clk_en,
  // Register port
  input wire logic [`ADDR_W-1:0]   reg_addr,
  input wire logic [`DATA_W-1:0]   reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [`DATA_W-1:0]   reg_rdata,
  // Line and MAC sides
  input line_status_pkg::line_in_t line_in,
  input wire logic                 mac_tx_active,
  input line_status_pkg::mac_out_t mac_out,
  input line_status_pkg::port_sel_t port_sel
);
  import line_status_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic [15:0] ctl_r;
  logic        fdx_r;
  logic [4:0]  quiet_r;
  logic        mapped;
  assign mapped = reg_addr inside {5'h08, 5'h0D, 5'h0E, 5'h13};
  // Shadow of control bits the checker needs
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctl_r <= 16'h0000;
      fdx_r <= 1'b0;
    end else if (reg_wr && clk_en) begin
      if (reg_addr == 5'h0D) ctl_r <= reg_wdata;
      if (reg_addr == 5'h13) fdx_r <= reg_wdata[14];
    end
  end
  // Cycles since the collision pair was last active
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) quiet_r <= 5'h00;
    else if (line_in.aui_collision) quiet_r <= 5'h00;
    else if (quiet_r != 5'h1F) quiet_r <= quiet_r + 5'h01;
  end
  rd_idle_a: assert property ($past(!reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read");
  unmapped_rd_a: assert property ($past(reg_rd && !mapped) |->
    reg_rdata == 16'h0000) else $error("unmapped read not zero");
  ctl_read_a: assert property ($past(reg_rd && reg_addr == 5'h0D) |->
    (reg_rdata & 16'h1300) == ($past(ctl_r) & 16'h1300))
    else $error("line control readback wrong");
  tp_col_a: assert property ((mac_tx_active && line_in.tp_rx_active &&
    !fdx_r)[*4] |-> mac_out.collision) else $error("missed TP collision");
  col_quiet_a: assert property ((quiet_r > 5'd16 &&
    !(mac_tx_active && line_in.tp_rx_active && !fdx_r))[*4]
    |-> !mac_out.collision) else $error("collision without cause");
  aui_col_a: assert property ($rose(line_in.aui_collision) &&
    port_sel == PORT_AUI |-> ##[1:4] mac_out.collision)
    else $error("missed AUI collision");
  port_aui_a: assert property (ctl_r[8][*3] |->
    port_sel == PORT_AUI) else $error("AUI only not selected");
  port_tp_a: assert property ((!ctl_r[8] && !ctl_r[9])[*3] |->
    port_sel == PORT_TP) else $error("TP only not selected");
endmodule // line_status_monitor
bind line_polarity_collision_aui_status line_status_monitor u_mon (
  .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_in(line_in),
  .mac_tx_active(mac_tx_active), .mac_out(mac_out), .port_sel(port_sel));

/* sim/line_polarity_collision_aui_status_bench.sv */
// Self-checking bench for the line status block
`timescale 1ns/1ps
module line_polarity_collision_aui_status_bench;
  import line_status_pkg::*;
  logic        core_clk, resetn, reg_wr, reg_rd, tx, loop_en, col_en;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [7:0]  lin;
  logic        p_car, p_col;
  line_in_t    li;
  mac_out_t    mo;
  port_sel_t   ps;
  int          n_mismatch, check_count, cyc;
  assign li = {lin[7:2], p_car, p_col};
  line_polarity_collision_aui_status #(.LINK_LOSS_CYC(200)) u_dut (
    .core_clk(core_clk), .resetn(resetn), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_in(li),
    .mac_tx_active(tx), .mac_out(mo), .port_sel(ps));
  line_far_end u_far (.core_clk(core_clk), .resetn(resetn),
    .mac_tx_active(tx), .loop_en(loop_en), .col_en(col_en),
    .aui_carrier(p_car), .aui_collision(p_col));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic give_verdict();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(logic [4:0] a, logic [15:0] v);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(logic [4:0] a, logic [15:0] m, logic [15:0] e);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, e);
  endtask
  task automatic drive(int b, logic v);
    @(posedge core_clk);
    lin[b] <= v;
  endtask
  task automatic pulse(int b, int n);
    repeat (n) begin
      drive(b, 1'b1);
      repeat (2) @(posedge core_clk);
      lin[b] <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
  endtask
  initial begin
    resetn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 5'h00;
    reg_wdata = 16'h0000; lin = 8'h00; tx = 1'b0; loop_en = 1'b0;
    col_en = 1'b0; n_mismatch = 0; check_count = 0; cyc = 0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    rdchk(5'h0D, 16'hFFFF, 16'h0000);
    rdchk(5'h1F, 16'hFFFF, 16'h0000);
    wr(5'h0E, 16'h0000);
    rdchk(5'h0E, 16'h1000, 16'h1000);
    // Frame after a lone inverted pulse is still suspect
    pulse(4, 1);
    drive(6, 1'b1);
    drive(7, 1'b1);
    tick(6);
    chk(16'(mo.rx_valid), 16'h0000);
    drive(7, 1'b0);
    pulse(2, 3);
    rdchk(5'h0E, 16'h1000, 16'h1000);
    pulse(2, 1);
    rdchk(5'h0E, 16'h1000, 16'h0000);
    drive(7, 1'b1);
    tick(6);
    chk(16'({mo.rx_valid, mo.rx_data}), 16'h0002);
    wr(5'h0D, 16'h1000);
    tick(4);
    chk(16'({mo.rx_valid, mo.rx_data}), 16'h0003);
    rdchk(5'h0E, 16'h1000, 16'h0000);
    drive(7, 1'b0);
    pulse(5, 4);
    rdchk(5'h0E, 16'h1000, 16'h1000);
    wr(5'h0D, 16'h0000);
    tx <= 1'b1;
    drive(7, 1'b1);
    tick(5);
    chk(16'(mo.collision), 16'h0001);
    chk(16'({mo.rx_valid, mo.rx_data}), 16'h0003);
    wr(5'h13, 16'h4000);
    tick(5);
    chk(16'(mo.collision), 16'h0000);
    tx <= 1'b0;
    drive(7, 1'b0);
    wr(5'h13, 16'h0000);
    wr(5'h0D, 16'h0100);
    col_en <= 1'b1;
    tick(10);
    chk(16'(mo.collision), 16'h0001);
    col_en <= 1'b0;
    tick(20);
    chk(16'(mo.collision), 16'h0000);
    for (int i = 0; i < 3; i++) begin
      wr(5'h0D, 16'h0100 * i);
      tick(3);
      chk(16'(ps), 16'(i == 1));
    end
    wr(5'h0D, 16'h0200);
    tick(250);
    chk(16'(ps), 16'h0001);
    rdchk(5'h0E, 16'h4088, 16'h0008);
    pulse(5, 1);
    tick(2);
    chk(16'(ps), 16'h0000);
    rdchk(5'h0E, 16'h0088, 16'h0080);
    wr(5'h0D, 16'h0100);
    rdchk(5'h08, 16'hFFFF, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      loop_en <= i[0];
      tx      <= 1'b1;
      tick(10);
      tx <= 1'b0;
      tick(4);
      rdchk(5'h08, 16'h0040, i ? 16'h0000 : 16'h0040);
      rdchk(5'h08, 16'h0040, 16'h0000);
    end
    // Carrier dropping mid-frame is a loss as well
    loop_en <= 1'b1;
    tx      <= 1'b1;
    tick(10);
    chk(16'(mo.carrier), 16'h0001);
    loop_en <= 1'b0;
    tick(8);
    tx <= 1'b0;
    tick(4);
    rdchk(5'h08, 16'hFFFF, 16'h0040);
    give_verdict();
  end
endmodule // line_polarity_collision_aui_status_bench
